// *** core/gmtp_pkg.sv ***
/*
  Constants, types and decode helpers shared by the gamma DAC and
  nonvolatile update controller.
  Assumes a 100 MHz core clock; counts are derived from that rate.
*/
package gmtp_pkg;
  localparam int DW = 10;
  localparam int NREG = 32;
  localparam int NCHAN = 19;
  localparam logic [7:0] ADDR_GMA_LAST = 8'h0F;
  localparam logic [7:0] ADDR_COM_VOLT = 8'h12;
  localparam logic [7:0] ADDR_VMIN = 8'h18;
  localparam logic [7:0] ADDR_VMAX = 8'h19;
  localparam logic [7:0] ADDR_LAST = 8'h1E;
  localparam logic [7:0] ADDR_PARK = 8'hFF;
  localparam logic [9:0] NV_DEF = 10'h200;
  localparam logic [9:0] VMIN_DEF = 10'h000;
  localparam logic [9:0] VMAX_DEF = 10'h3FF;
  localparam logic [1:0] WC_NONE0 = 2'h0;
  localparam logic [1:0] WC_NV = 2'h1;
  localparam logic [1:0] WC_DAC = 2'h2;
  localparam logic [1:0] MX_ACQ_ONE = 2'h1;
  localparam logic [1:0] MX_ACQ_ALL = 2'h2;
  localparam int CLK_MHZ = 100;
  localparam int LOAD_US = 300;
  localparam int BUSY_MIN_MS = 31;
  localparam int BUSY_MAX_MS = 500;
  localparam int LOAD_CYC_DEF = LOAD_US * CLK_MHZ;
  localparam int BUSY_MIN_CYC_DEF = BUSY_MIN_MS * 1000 * CLK_MHZ;
  localparam int BUSY_MAX_CYC_DEF = BUSY_MAX_MS * 1000 * CLK_MHZ;
  localparam int BUSY_STEP_CYC_DEF = (BUSY_MAX_CYC_DEF - BUSY_MIN_CYC_DEF) / (NCHAN - 1);

  typedef enum logic [1:0] {
    EV_WORD = 2'b00,
    EV_ACQ_ONE = 2'b01,
    EV_ACQ_ALL = 2'b10,
    EV_STOP = 2'b11
  } gmtp_ev_t;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } gmtp_st_t;

  // Addresses that hold a real channel word
  function automatic logic is_chan(input logic [7:0] a);
    return (a <= ADDR_GMA_LAST) || (a == ADDR_COM_VOLT) || (a == ADDR_VMIN) || (a == ADDR_VMAX);
  endfunction : is_chan

  function automatic logic [9:0] nv_init(input int idx);
    if (idx == int'(ADDR_VMIN)) return VMIN_DEF;
    if (idx == int'(ADDR_VMAX)) return VMAX_DEF;
    return NV_DEF;
  endfunction : nv_init
endpackage : gmtp_pkg

// *** core/gmtp_update_ctrl.sv ***
/*
  Update controller for interface, DAC buffer, output and nonvolatile banks.
  Link side runs on the bus clock and takes already deframed bytes: a start
  marker, a stop marker and a strobed byte (first byte after start is the
  register address). Events cross to the core clock by toggle.
*/
// Notes on behaviour
// - Deferred burst words fill DAC buffers; outputs flip together on the word carrying code 10.
// - One transaction may write every register, address advancing to ADDR_LAST, then parked at ADDR_PARK.
// - Reserved addresses in a burst drop data but both bytes are acknowledged.
// - Nonvolatile copy programmable by single word or by burst.
// - First byte pair goes to named address, each later pair to the next.
// - Burst commits all nonvolatile registers after last pair carrying code 01.
// - Stop before the code 01 pair leaves nonvolatile bank untouched.
// - Single nonvolatile write commits when the final data bit arrives.
// - Nonvolatile programming also loads DAC buffers and outputs at once.
// - Busy 31 to 500 ms by register count; no acknowledge meanwhile.
// - Address top bits 10 reload all DACs and outputs from nonvolatile.
// - Address top bits 01 reload only the addressed channel from nonvolatile.
// - After power-up copy nonvolatile bank into interface bank, about 300 us.
// - Write code 00/11 nothing, 01 all nonvolatile, 10 all DACs.
// - Words travel as two bytes; top two bits are control, ten stored.
`timescale 1ns/1ps
`default_nettype none
module gmtp_update_ctrl import gmtp_pkg::*; #(
  parameter int unsigned LOAD_CYC = LOAD_CYC_DEF,
  parameter int unsigned BUSY_MIN_CYC = BUSY_MIN_CYC_DEF,
  parameter int unsigned BUSY_MAX_CYC = BUSY_MAX_CYC_DEF,
  parameter int unsigned BUSY_STEP_CYC = BUSY_STEP_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  input wire logic link_rst_i,
  input wire logic lk_start_i,
  input wire logic lk_stop_i,
  input wire logic lk_byte_vld_i,
  input wire logic [7:0] lk_byte_i,
  output logic lk_ack_o,
  output logic [NREG*DW-1:0] dac_out_o,
  output logic busy_o,
  output logic loading_o
);
  if (BUSY_MIN_CYC < 8 || BUSY_MAX_CYC < BUSY_MIN_CYC || LOAD_CYC < 2) begin : g_chk
    $error("gmtp_update_ctrl: unusable busy or load cycle counts");
  end

  // ---------------- Link domain ----------------
  logic addr_phase_q, addr_phase_d, hi_have_q, hi_have_d, ev_tgl_q, ev_tgl_d;
  logic bsy_s1_q, bsy_s2_q, ack_q;
  logic [7:0] hi_q, hi_d, ptr_q, ptr_d, ev_addr_q, ev_addr_d;
  logic [9:0] ev_data_q, ev_data_d;
  logic [1:0] ev_wc_q, ev_wc_d;
  gmtp_ev_t ev_kind_q, ev_kind_d;

  always_comb begin
    addr_phase_d = addr_phase_q;
    hi_have_d = hi_have_q;
    hi_d = hi_q;
    ptr_d = ptr_q;
    ev_tgl_d = ev_tgl_q;
    ev_kind_d = ev_kind_q;
    ev_addr_d = ev_addr_q;
    ev_data_d = ev_data_q;
    ev_wc_d = ev_wc_q;
    if (lk_start_i) begin
      addr_phase_d = 1'b1;
      hi_have_d = 1'b0;
    end else if (lk_stop_i) begin
      addr_phase_d = 1'b0;
      hi_have_d = 1'b0;
      ev_kind_d = EV_STOP;
      ev_tgl_d = ~ev_tgl_q;
    end else if (lk_byte_vld_i && !bsy_s2_q) begin
      if (addr_phase_q) begin
        addr_phase_d = 1'b0;
        ptr_d = {2'b00, lk_byte_i[5:0]};
        ev_addr_d = {2'b00, lk_byte_i[5:0]};
        if (lk_byte_i[7:6] == MX_ACQ_ALL) begin
          ev_kind_d = EV_ACQ_ALL;
          ev_tgl_d = ~ev_tgl_q;
        end else if (lk_byte_i[7:6] == MX_ACQ_ONE) begin
          ev_kind_d = EV_ACQ_ONE;
          ev_tgl_d = ~ev_tgl_q;
        end
      end else if (!hi_have_q) begin
        hi_d = lk_byte_i;
        hi_have_d = 1'b1;
      end else begin
        ev_kind_d = EV_WORD;
        ev_addr_d = ptr_q;
        ev_data_d = {hi_q[1:0], lk_byte_i};
        ev_wc_d = hi_q[7:6];
        ev_tgl_d = ~ev_tgl_q;
        hi_have_d = 1'b0;
        ptr_d = (ptr_q >= ADDR_LAST) ? ADDR_PARK : ptr_q + 8'h01;
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      addr_phase_q <= 1'b0;
      hi_have_q <= 1'b0;
      hi_q <= 8'h00;
      ptr_q <= 8'h00;
      ev_tgl_q <= 1'b0;
      ev_kind_q <= EV_STOP;
      ev_addr_q <= 8'h00;
      ev_data_q <= 10'h000;
      ev_wc_q <= WC_NONE0;
      bsy_s1_q <= 1'b1;
      bsy_s2_q <= 1'b1;
      ack_q <= 1'b0;
    end else begin
      addr_phase_q <= addr_phase_d;
      hi_have_q <= hi_have_d;
      hi_q <= hi_d;
      ptr_q <= ptr_d;
      ev_tgl_q <= ev_tgl_d;
      ev_kind_q <= ev_kind_d;
      ev_addr_q <= ev_addr_d;
      ev_data_q <= ev_data_d;
      ev_wc_q <= ev_wc_d;
      bsy_s1_q <= busy_o;
      bsy_s2_q <= bsy_s1_q;
      ack_q <= !bsy_s2_q;
    end
  end
  assign lk_ack_o = ack_q;

  // ---------------- Core domain ----------------
  logic tg_s1_q, tg_s2_q, tg_s3_q, busy_q, busy_d, loading_q, loading_d, fire;
  logic [31:0] cnt_q, cnt_d;
  logic [5:0] nwords_q, nwords_d;
  logic [4:0] idx;
  logic [NREG-1:0][DW-1:0] iface_q, iface_d, dac_q, dac_d, out_q, out_d, nv_q, nv_d;
  gmtp_st_t st_q, st_d;

  // Busy time grows with the number of channel words in the burst
  function automatic logic [31:0] busy_len(input logic [5:0] n);
    logic [63:0] t;
    t = 64'(BUSY_MIN_CYC) + 64'(n - 6'd1) * 64'(BUSY_STEP_CYC);
    if (t > 64'(BUSY_MAX_CYC)) t = 64'(BUSY_MAX_CYC);
    return t[31:0];
  endfunction : busy_len

  assign fire = tg_s2_q ^ tg_s3_q;
  assign idx = ev_addr_q[4:0];

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    nwords_d = nwords_q;
    iface_d = iface_q;
    dac_d = dac_q;
    out_d = out_q;
    nv_d = nv_q;
    case (st_q)
      ST_LOAD: begin
        cnt_d = cnt_q - 32'h0000_0001;
        if (cnt_q <= 32'h0000_0001) begin
          iface_d = nv_q;
          dac_d = nv_q;
          out_d = nv_q;
          st_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (fire) begin
          case (ev_kind_q)
            EV_WORD: begin
              if (is_chan(ev_addr_q)) begin
                iface_d[idx] = ev_data_q;
                dac_d[idx] = ev_data_q;
                nwords_d = nwords_q + 6'd1;
              end
              if (ev_wc_q == WC_DAC) begin
                out_d = dac_d;
              end else if (ev_wc_q == WC_NV) begin
                nv_d = iface_d;
                dac_d = iface_d;
                out_d = iface_d;
                st_d = ST_BUSY;
                cnt_d = busy_len((nwords_d == 6'd0) ? 6'd1 : nwords_d);
                nwords_d = 6'd0;
              end
            end
            EV_ACQ_ONE: begin
              if (is_chan(ev_addr_q)) begin
                iface_d[idx] = nv_q[idx];
                dac_d[idx] = nv_q[idx];
                out_d[idx] = nv_q[idx];
              end
            end
            EV_ACQ_ALL: begin
              iface_d = nv_q;
              dac_d = nv_q;
              out_d = nv_q;
            end
            default: nwords_d = 6'd0;
          endcase
        end
      end
      ST_BUSY: begin
        cnt_d = cnt_q - 32'h0000_0001;
        if (cnt_q <= 32'h0000_0001) st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    busy_d = (st_d != ST_IDLE);
    loading_d = (st_d == ST_LOAD);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tg_s1_q <= 1'b0;
      tg_s2_q <= 1'b0;
      tg_s3_q <= 1'b0;
      st_q <= ST_LOAD;
      cnt_q <= 32'(LOAD_CYC);
      nwords_q <= 6'd0;
      busy_q <= 1'b1;
      loading_q <= 1'b1;
      for (int i = 0; i < NREG; i++) begin
        iface_q[i] <= nv_init(i);
        dac_q[i] <= nv_init(i);
        out_q[i] <= nv_init(i);
        nv_q[i] <= nv_init(i);
      end
    end else begin
      tg_s1_q <= ev_tgl_q;
      tg_s2_q <= tg_s1_q;
      tg_s3_q <= tg_s2_q;
      st_q <= st_d;
      cnt_q <= cnt_d;
      nwords_q <= nwords_d;
      busy_q <= busy_d;
      loading_q <= loading_d;
      iface_q <= iface_d;
      dac_q <= dac_d;
      out_q <= out_d;
      nv_q <= nv_d;
    end
  end
  assign dac_out_o = out_q;
  assign busy_o = busy_q;
  assign loading_o = loading_q;

  // ---------------- Checks ----------------
  chk_defer_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && st_q == ST_IDLE && ev_kind_q == EV_WORD && ev_wc_q == WC_NONE0 |=> $stable(out_q))
    else $error("outputs moved on a deferred word");
  chk_dac_flip: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && st_q == ST_IDLE && ev_kind_q == EV_WORD && ev_wc_q == WC_DAC |=> out_q == dac_q)
    else $error("outputs not taken from DAC buffers");
  chk_reserved_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && st_q == ST_IDLE && ev_kind_q == EV_WORD && !is_chan(ev_addr_q)
      && ev_wc_q == WC_NONE0 |=> $stable(iface_q))
    else $error("reserved address data was stored");
  chk_nv_commit: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && st_q == ST_IDLE && ev_kind_q == EV_WORD && ev_wc_q == WC_NV
      |=> busy_o && nv_q == iface_q && out_q == nv_q)
    else $error("nonvolatile commit incomplete");
  chk_stop_keeps_nv: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && ev_kind_q == EV_STOP |=> $stable(nv_q))
    else $error("stop changed nonvolatile bank");
  chk_busy_min: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(busy_q) |-> busy_q [*8])
    else $error("busy period too short");
  chk_busy_max: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_BUSY |-> cnt_q <= 32'(BUSY_MAX_CYC))
    else $error("busy period beyond maximum");
  chk_nack_busy: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    bsy_s2_q |=> !lk_ack_o)
    else $error("acknowledge given while busy");
  chk_acq_all: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && st_q == ST_IDLE && ev_kind_q == EV_ACQ_ALL |=> out_q == nv_q && dac_q == nv_q)
    else $error("general acquire missed");
  chk_acq_one: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && st_q == ST_IDLE && ev_kind_q == EV_ACQ_ONE && is_chan(ev_addr_q)
      |=> out_q[idx] == nv_q[idx])
    else $error("single acquire missed");
  chk_load_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(loading_q) |-> iface_q == nv_q && !busy_q)
    else $error("power-up load incomplete");
  chk_ptr_step: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    lk_byte_vld_i && !lk_start_i && !lk_stop_i && !bsy_s2_q && !addr_phase_q && hi_have_q
      |=> ev_kind_q == EV_WORD && ev_addr_q == $past(ptr_q))
    else $error("word paired to wrong address");

  cov_dac_flip: cover property (@(posedge clk_i) disable iff (rst_i)
    fire && st_q == ST_IDLE && ev_kind_q == EV_WORD && ev_wc_q == WC_DAC);
  cov_nv_commit: cover property (@(posedge clk_i) disable iff (rst_i) $fell(busy_q) && !$past(loading_q));
  cov_acq_all: cover property (@(posedge clk_i) disable iff (rst_i)
    fire && st_q == ST_IDLE && ev_kind_q == EV_ACQ_ALL);
  cov_load_done: cover property (@(posedge clk_i) disable iff (rst_i) $fell(loading_q));
endmodule : gmtp_update_ctrl
`default_nettype wire

// *** tb/gmtp_link_master.sv ***
/*
  Link master model: start, stop and byte strobes on the link clock.
  Assumes the bench makes the link clock and calls these tasks in order.
*/
`timescale 1ns/1ps
`default_nettype none
module gmtp_link_master (
  input wire logic link_clk_i,
  input wire logic lk_ack_i,
  output logic lk_start_o,
  output logic lk_stop_o,
  output logic lk_byte_vld_o,
  output logic [7:0] lk_byte_o
);
  initial begin
    lk_start_o = 1'b0;
    lk_stop_o = 1'b0;
    lk_byte_vld_o = 1'b0;
    lk_byte_o = 8'h00;
  end
  task automatic gap();
    repeat (8) @(posedge link_clk_i);
  endtask : gap
  task automatic put_byte(input logic [7:0] b);
    gap();
    lk_byte_vld_o <= 1'b1;
    lk_byte_o <= b;
    @(posedge link_clk_i);
    lk_byte_vld_o <= 1'b0;
    lk_byte_o <= ~b;
  endtask : put_byte
  task automatic mark(input logic st);
    gap();
    lk_start_o <= st;
    lk_stop_o <= ~st;
    @(posedge link_clk_i);
    lk_start_o <= 1'b0;
    lk_stop_o <= 1'b0;
  endtask : mark
  // Hold off until the device acknowledges again
  task automatic open_at(input logic [1:0] mx, input logic [5:0] a);
    wait (lk_ack_i === 1'b1);
    mark(1'b1);
    put_byte({mx, a});
  endtask : open_at
  task automatic put_word(input logic [1:0] wc, input logic [9:0] d);
    put_byte({wc, 4'h0, d[9:8]});
    put_byte(d[7:0]);
  endtask : put_word
endmodule : gmtp_link_master
`default_nettype wire

// *** tb/gamma_dac_mtp_update_control_tb_top.sv ***
/*
  Bench for the update controller: link transactions and bank checks.
  Assumes the default load count and the shortened busy counts set below.
*/
`timescale 1ns/1ps
`default_nettype none
module gamma_dac_mtp_update_control_tb_top;
  import gmtp_pkg::*;
  localparam int LC = LOAD_CYC_DEF;
  localparam int BMIN = 40;
  localparam int BSTEP = 5;
  logic clk_i, rst_i, link_clk_i, link_rst_i, lk_ack_o, busy_o, loading_o;
  logic lk_start_i, lk_stop_i, lk_byte_vld_i;
  logic [7:0] lk_byte_i;
  logic [NREG*DW-1:0] dac_out_o;
  logic [9:0] ev [NREG];
  logic [9:0] nv [NREG];
  logic [9:0] d;
  int bad_count, total_checks, c;
  gmtp_update_ctrl #(.BUSY_MIN_CYC(BMIN),
    .BUSY_STEP_CYC(BSTEP)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
    .link_rst_i(link_rst_i), .lk_start_i(lk_start_i), .lk_stop_i(lk_stop_i),
    .lk_byte_vld_i(lk_byte_vld_i), .lk_byte_i(lk_byte_i), .lk_ack_o(lk_ack_o),
    .dac_out_o(dac_out_o), .busy_o(busy_o), .loading_o(loading_o));
  gmtp_link_master u_mst (.link_clk_i(link_clk_i), .lk_ack_i(lk_ack_o),
    .lk_start_o(lk_start_i), .lk_stop_o(lk_stop_i), .lk_byte_vld_o(lk_byte_vld_i),
    .lk_byte_o(lk_byte_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #2.3;
    forever #7.5 link_clk_i = ~link_clk_i;
  end
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [9:0] got, input logic [9:0] want);
    total_checks++;
    if (got !== want) begin
      bad_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, want);
    end
  endtask : chk
  function automatic logic is_ch(input int a);
    return a <= 15 || a == 18 || a == 24 || a == 25;
  endfunction : is_ch
  task automatic chk_all();
    for (int a = 0; a < NREG; a++) if (is_ch(a)) chk(dac_out_o[a*DW +: DW], ev[a]);
  endtask : chk_all
  task automatic settle();
    repeat (12) @(posedge clk_i);
  endtask : settle
  task automatic busy_len(input int want);
    int n;
    n = 20;
    repeat (20) @(posedge clk_i);
    chk({9'h0, lk_ack_o}, 10'h000);
    while (busy_o === 1'b1 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    chk({9'h0, n >= want + 2 && n <= want + 9}, 10'h001);
  endtask : busy_len
  initial begin
    #600000;
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end
  initial begin
    bad_count = 0;
    total_checks = 0;
    rst_i = 1'b1;
    link_rst_i = 1'b1;
    for (int a = 0; a < NREG; a++) ev[a] = a == 24 ? 10'h000 : a == 25 ? 10'h3FF : 10'h200;
    nv = ev;
    repeat (8) @(posedge clk_i);
    chk({8'h0, busy_o, loading_o}, 10'h003);
    chk({9'h0, lk_ack_o}, 10'h000);
    chk_all();
    rst_i <= 1'b0;
    @(posedge link_clk_i);
    link_rst_i <= 1'b0;
    c = 0;
    while (loading_o === 1'b1 && c < LC + 10) begin
      @(posedge clk_i);
      c++;
    end
    chk({9'h0, c >= LC - 2 && c <= LC + 2}, 10'h001);
    chk({8'h0, busy_o, loading_o}, 10'h000);
    chk_all();
    $display("Test power-up load done");
    u_mst.open_at(2'b00, 6'h05);
    u_mst.put_word(WC_NV, 10'h155);
    ev[5] = 10'h155;
    nv[5] = 10'h155;
    busy_len(BMIN);
    chk_all();
    u_mst.mark(1'b0);
    $display("Test single nonvolatile write done");
    u_mst.open_at(2'b00, 6'h00);
    for (int a = 0; a <= 25; a++) begin
      d = 10'(a * 37 + 17);
      u_mst.put_word(a == 25 ? WC_DAC : a[0] ? 2'b11 : WC_NONE0, d);
      if (a == 3) begin
        settle();
        chk_all();
      end
    end
    for (int a = 0; a <= 25; a++) ev[a] = 10'(a * 37 + 17);
    settle();
    chk_all();
    chk({9'h0, lk_ack_o}, 10'h001);
    u_mst.mark(1'b0);
    $display("Test deferred burst done");
    u_mst.open_at(2'b00, 6'h00);
    u_mst.put_word(WC_NONE0, 10'h0AA);
    u_mst.put_word(WC_NONE0, 10'h0BB);
    u_mst.mark(1'b0);
    u_mst.open_at(MX_ACQ_ONE, 6'h01);
    settle();
    ev[1] = nv[1];
    chk_all();
    u_mst.mark(1'b0);
    u_mst.open_at(MX_ACQ_ALL, 6'h2A);
    settle();
    ev = nv;
    chk_all();
    u_mst.mark(1'b0);
    $display("Test abort and acquire done");
    u_mst.open_at(2'b00, 6'h03);
    u_mst.put_word(WC_NONE0, 10'h311);
    u_mst.put_word(WC_NONE0, 10'h122);
    settle();
    chk(dac_out_o[3*DW +: DW], ev[3]);
    u_mst.put_word(WC_NV, 10'h233);
    busy_len(BMIN + 2 * BSTEP);
    chk(dac_out_o[3*DW +: DW], 10'h311);
    chk(dac_out_o[5*DW +: DW], 10'h233);
    u_mst.mark(1'b0);
    u_mst.open_at(MX_ACQ_ALL, 6'h00);
    settle();
    chk(dac_out_o[4*DW +: DW], 10'h122);
    u_mst.mark(1'b0);
    $display("Test nonvolatile burst done");
    end_of_test();
  end
endmodule : gamma_dac_mtp_update_control_tb_top
`default_nettype wire
